// File: hw/cycle_timer.sv
// Down counter used for CPU stalls and programming time.
// Assumes same-clock load pulses.
`timescale 1ns/1ps
module cycle_timer #(
    parameter int W = 20
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic load, // Load start value
    input wire logic [W-1:0] value, // Start value
    output logic busy, // Count not yet zero
    output logic done // One-cycle pulse on reaching zero
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // Next count
    assign cnt_next = load ? value : (cnt_reg != '0 ? cnt_reg - 1'b1 : cnt_reg);
    assign busy = (cnt_reg != '0);

    // Counter and terminal pulse
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            done <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            done <= !load && (cnt_reg == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule : cycle_timer

// File: hw/data_memory.sv
// Data space decoder, pointer addressing, program memory read path and
// nonvolatile byte store access. Assumes a CPU core on the same clock
// holding each request for one cycle and honouring cpu_stall.
`timescale 1ns/1ps
`include "data_memory_defines.svh"
module data_memory #(
    parameter int CYC_ATOMIC = `CYC_ATOMIC, // Atomic programming time in cycles
    parameter int CYC_SPLIT = `CYC_SPLIT // Split programming time in cycles
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic req, // Data access request pulse
    input wire logic req_we, // Request is a store
    input wire data_memory_pkg::addr_mode_t req_mode, // Addressing mode
    input wire logic [15:0] req_addr, // Direct address
    input wire logic [1:0] req_ptr, // Pointer: 0 X, 1 Y, 2 Z
    input wire logic [5:0] req_disp, // Displacement
    input wire logic [7:0] req_wdata, // Store data
    output logic [7:0] rdata, // Load data
    output logic rvalid, // Load data valid pulse
    input wire logic pm_req, // Program memory read pulse
    input wire logic [15:0] pm_byte_addr, // Byte address into program memory
    output logic [7:0] pm_rdata, // Program memory byte
    output logic pm_rvalid, // Program memory byte valid pulse
    input wire logic [9:0] program_counter, // Fetch address
    output logic [15:0] instr, // Fetched word
    input wire logic pm_load, // Load one program word
    input wire logic [9:0] pm_load_addr, // Word address to load
    input wire logic [15:0] pm_load_data, // Word to load
    output logic cpu_stall, // Hold the CPU
    output logic [7:0] nv_cell_view // Byte at current nonvolatile address
);
    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] gpr [0:31];
    logic [7:0] sram [0:`DM_SRAM_WORDS-1];
    logic [15:0] pmem [0:`PM_WORDS-1];
    logic [7:0] nv_mem [0:`NV_BYTES-1];

    logic [6:0] eeprom_byte_address_reg;
    logic [7:0] eeprom_byte_buffer_reg;
    logic nv_master_write_arm_reg;
    logic nv_write_go_reg;
    logic [1:0] nv_prog_mode_reg;
    logic [2:0] arm_cnt_reg;
    data_memory_pkg::nv_state_t nv_state_reg;
    data_memory_pkg::nv_state_t nv_state_next;
    data_memory_pkg::prog_mode_t op_reg;

    // ************************************************************
    // Address generation
    // ************************************************************
    logic [4:0] ptr_lo;
    logic [15:0] ptr_val;
    logic [15:0] ptr_dec;
    logic [15:0] ea;
    logic ptr_upd;

    // Pointer pair select and effective address
    assign ptr_lo = (req_ptr == 2'd0) ? `PTR_X_LO : ((req_ptr == 2'd1) ? `PTR_Y_LO : `PTR_Z_LO);
    assign ptr_val = {gpr[ptr_lo + 5'd1], gpr[ptr_lo]};
    assign ptr_dec = ptr_val - 16'h0001;
    assign ea = (req_mode == data_memory_pkg::AM_DIRECT) ? req_addr :
                (req_mode == data_memory_pkg::AM_DISP) ? ptr_val + {10'h000, req_disp} :
                (req_mode == data_memory_pkg::AM_PREDEC) ? ptr_dec : ptr_val;
    assign ptr_upd = req && (req_mode == data_memory_pkg::AM_PREDEC
                     || req_mode == data_memory_pkg::AM_POSTINC);

    // Region decode
    logic in_reg;
    logic in_io;
    logic in_sram;
    logic [5:0] io_off;
    logic [6:0] sram_off;
    assign in_reg = ea < `DM_REG_END;
    assign in_io = !in_reg && ea < `DM_IO_END;
    assign in_sram = !in_reg && !in_io && ea < `DM_MAP_END;
    assign io_off = 6'(ea - `DM_REG_END);
    assign sram_off = 7'(ea - `DM_IO_END);

    // ************************************************************
    // Byte store register decode
    // ************************************************************
    logic io_wr;
    logic wr_addr;
    logic wr_buf;
    logic wr_ctrl;
    logic nv_busy;
    logic start_read;
    logic start_go;
    logic [7:0] ctrl_rd;
    logic [7:0] io_rd;
    assign io_wr = req && req_we && in_io && !cpu_stall;
    assign wr_addr = io_wr && io_off == `IO_NV_ADDR;
    assign wr_buf = io_wr && io_off == `IO_NV_BUF;
    assign wr_ctrl = io_wr && io_off == `IO_NV_CTRL;
    assign nv_busy = nv_write_go_reg;
    assign start_read = wr_ctrl && req_wdata[`CTRL_READ] && !nv_busy;
    assign start_go = wr_ctrl && req_wdata[`CTRL_GO] && nv_master_write_arm_reg
                      && !nv_busy && req_wdata[5:4] != 2'b11;
    assign ctrl_rd = {2'b00, nv_prog_mode_reg, 1'b0, nv_master_write_arm_reg,
                      nv_write_go_reg, 1'b0};
    assign io_rd = (io_off == `IO_NV_ADDR) ? {1'b0, eeprom_byte_address_reg} :
                   (io_off == `IO_NV_BUF) ? eeprom_byte_buffer_reg :
                   (io_off == `IO_NV_CTRL) ? ctrl_rd : 8'h00;

    // Read data mux; unmapped reads return zero
    logic [7:0] rd_mux;
    assign rd_mux = in_reg ? gpr[ea[4:0]] : in_io ? io_rd :
                    in_sram ? sram[sram_off] : 8'h00;

    // ************************************************************
    // Stall and programming timers
    // ************************************************************
    logic stall_busy;
    logic [2:0] stall_val;
    logic prog_busy;
    logic prog_done;
    logic [19:0] prog_val;
    // Timer counts the stall cycles after the first; the registered start pulse holds the first
    assign stall_val = start_read ? `STALL_READ - 3'h1 : `STALL_WRITE - 3'h1;
    assign prog_val = (req_wdata[5:4] == 2'b00) ? 20'(CYC_ATOMIC) : 20'(CYC_SPLIT);

    cycle_timer #(.W(3)) u_stall (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(start_read || start_go),
        .value(stall_val),
        .busy(stall_busy),
        .done()
    );

    cycle_timer #(.W(20)) u_prog (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(start_go),
        .value(prog_val),
        .busy(prog_busy),
        .done(prog_done)
    );

    // Sequencer next state
    always_comb
    begin
        nv_state_next = nv_state_reg;
        case (nv_state_reg)
            data_memory_pkg::NV_IDLE:
                if (start_go)
                    nv_state_next = data_memory_pkg::NV_BUSY;
            data_memory_pkg::NV_BUSY:
                if (prog_done)
                    nv_state_next = data_memory_pkg::NV_DONE;
            data_memory_pkg::NV_DONE:
                nv_state_next = data_memory_pkg::NV_IDLE;
            default:
                nv_state_next = data_memory_pkg::NV_IDLE;
        endcase
    end

    // ************************************************************
    // Data path state
    // ************************************************************
    // Working registers, SRAM and pointer update
    always_ff @(posedge clk_sys)
    begin
        if (req && req_we && in_reg && !cpu_stall)
            gpr[ea[4:0]] <= req_wdata;
        if (ptr_upd && !cpu_stall)
        begin
            gpr[ptr_lo] <= (req_mode == data_memory_pkg::AM_PREDEC) ? ptr_dec[7:0] : 8'(ptr_val + 16'h0001);
            gpr[ptr_lo + 5'd1] <= (req_mode == data_memory_pkg::AM_PREDEC) ? ptr_dec[15:8] : 8'((ptr_val + 16'h0001) >> 8);
        end
        if (req && req_we && in_sram && !cpu_stall)
            sram[sram_off] <= req_wdata;
    end

    // Load answers one cycle after request, within two cycles
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req && !req_we && !cpu_stall;
            rdata <= rd_mux;
        end
    end

    // Program memory: fetch and byte read over full space
    always_ff @(posedge clk_sys)
    begin
        if (pm_load)
            pmem[pm_load_addr] <= pm_load_data;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            instr <= 16'h0000;
            pm_rdata <= 8'h00;
            pm_rvalid <= 1'b0;
        end
        else
        begin
            instr <= pmem[program_counter];
            pm_rdata <= pm_byte_addr[0] ? pmem[pm_byte_addr[10:1]][15:8] : pmem[pm_byte_addr[10:1]][7:0];
            pm_rvalid <= pm_req;
        end
    end

    // Address register keeps no reset value; writes blocked while busy
    always_ff @(posedge clk_sys)
    begin
        if (wr_addr && !nv_busy)
            eeprom_byte_address_reg <= req_wdata[6:0];
    end

    // Nonvolatile cell update at end of programming
    always_ff @(posedge clk_sys)
    begin
        if (prog_done)
        begin
            case (op_reg)
                data_memory_pkg::PM_ATOMIC: nv_mem[eeprom_byte_address_reg] <= eeprom_byte_buffer_reg;
                data_memory_pkg::PM_ERASE: nv_mem[eeprom_byte_address_reg] <= 8'hFF;
                data_memory_pkg::PM_WRITE: nv_mem[eeprom_byte_address_reg] <= nv_mem[eeprom_byte_address_reg] & eeprom_byte_buffer_reg;
                default: nv_mem[eeprom_byte_address_reg] <= nv_mem[eeprom_byte_address_reg];
            endcase
        end
    end

    // Control bits, buffer, arming window and CPU stall
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            eeprom_byte_buffer_reg <= 8'h00;
            nv_master_write_arm_reg <= 1'b0;
            nv_write_go_reg <= 1'b0;
            nv_prog_mode_reg <= 2'b00;
            arm_cnt_reg <= 3'h0;
            nv_state_reg <= data_memory_pkg::NV_IDLE;
            op_reg <= data_memory_pkg::PM_ATOMIC;
            cpu_stall <= 1'b0;
            nv_cell_view <= 8'h00;
        end
        else
        begin
            nv_state_reg <= nv_state_next;
            cpu_stall <= start_read || start_go || stall_busy;
            nv_cell_view <= nv_mem[eeprom_byte_address_reg];
            if (start_read)
                eeprom_byte_buffer_reg <= nv_mem[eeprom_byte_address_reg];
            else if (wr_buf)
                eeprom_byte_buffer_reg <= req_wdata;
            if (wr_ctrl && !nv_busy)
                nv_prog_mode_reg <= req_wdata[5:4];
            if (start_go)
            begin
                nv_write_go_reg <= 1'b1;
                op_reg <= data_memory_pkg::prog_mode_t'(req_wdata[5:4]);
            end
            else if (prog_done)
                nv_write_go_reg <= 1'b0;
            if (wr_ctrl && req_wdata[`CTRL_ARM] && !start_go)
            begin
                nv_master_write_arm_reg <= 1'b1;
                arm_cnt_reg <= `ARM_WINDOW;
            end
            else if (arm_cnt_reg > 3'h1)
                arm_cnt_reg <= arm_cnt_reg - 3'h1;
            else
            begin
                arm_cnt_reg <= 3'h0;
                nv_master_write_arm_reg <= 1'b0;
            end
        end
    end
endmodule : data_memory

// File: hw/data_memory_defines.svh
// Constants for the data memory and nonvolatile byte store access block.
// Assumes a single 200 MHz clock; included by bare name from the design files.
// Operation
// - Lowest 224 data addresses are mapped.
// - First 32 addresses select working registers.
// - Next 64 are I/O, next 128 SRAM.
// - Direct addressing reaches whole data space.
// - Y or Z base plus displacement 0..63; the code also accepts X as base.
// - Pre-decrement and post-increment update the pointer.
// - Registers 26 to 31 form X, Y, Z.
// - SRAM access completes within two cycles.
// - Program memory is 1K words of 16.
// - Program counter is 10 bits wide.
// - Program memory reads reach every address.
// - Byte store holds 128 bytes, separate space.
// - Byte store control sits in I/O space.
// - Self-timed write with readable busy bit.
// - Read stalls the CPU four cycles.
// - Write start stalls the CPU two cycles.
// - Address register top bit reads zero.
// - Low seven address bits select byte 0..127.
// - Address undefined after reset; software loads it.
// - Go works only within four cycles of arm.
// - Go bit stays set until write time ends.
// - Mode field: 00 atomic, 01 erase, 10 write.
// - Busy blocks reads and address register writes.
`ifndef DATA_MEMORY_DEFINES_SVH
`define DATA_MEMORY_DEFINES_SVH

// Data space layout
`define DM_REG_END 16'h0020
`define DM_IO_END 16'h0060
`define DM_MAP_END 16'h00E0
`define DM_SRAM_WORDS 128
`define DM_DISP_MAX 6'h3F

// Pointer register numbers
`define PTR_X_LO 5'h1A
`define PTR_Y_LO 5'h1C
`define PTR_Z_LO 5'h1E

// Program memory
`define PM_WORDS 1024
`define PC_BITS 10

// Byte store I/O offsets inside the 64-entry I/O space
`define IO_NV_ADDR 6'h1E
`define IO_NV_BUF 6'h1D
`define IO_NV_CTRL 6'h1C
`define NV_BYTES 128

// Control register fields
`define CTRL_READ 0
`define CTRL_GO 1
`define CTRL_ARM 2
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 5

// Timing
`define ARM_WINDOW 3'h4
`define STALL_READ 3'h4
`define STALL_WRITE 3'h2
`define T_ATOMIC_US 3400
`define T_SPLIT_US 1800
`define CLK_MHZ 200
`define CYC_ATOMIC (`T_ATOMIC_US * `CLK_MHZ)
`define CYC_SPLIT (`T_SPLIT_US * `CLK_MHZ)

`endif

// File: hw/data_memory_pkg.sv
// Types shared by the data memory block.
// Assumes the defines header is compiled alongside.
package data_memory_pkg;
    // Addressing modes of a data access
    typedef enum logic [2:0] {
        AM_DIRECT = 3'h0,
        AM_INDIRECT = 3'h1,
        AM_DISP = 3'h2,
        AM_PREDEC = 3'h3,
        AM_POSTINC = 3'h4
    } addr_mode_t;

    // Programming operation selected by the mode field
    typedef enum logic [1:0] {
        PM_ATOMIC = 2'h0,
        PM_ERASE = 2'h1,
        PM_WRITE = 2'h2,
        PM_RESERVED = 2'h3
    } prog_mode_t;

    // Nonvolatile write sequencer, Gray coded except the DONE to IDLE step
    typedef enum logic [1:0] {
        NV_IDLE = 2'b00,
        NV_BUSY = 2'b01,
        NV_DONE = 2'b11
    } nv_state_t;
endpackage : data_memory_pkg

// File: tb/cpu_model.sv
// CPU side partner: issues one data access at a time.
// Assumes the data memory clock and its stall handshake.
`timescale 1ns/1ps
module cpu_model (
    input wire logic clk_sys, // Clock
    input wire logic cpu_stall, // Hold requests
    input wire logic [7:0] rdata, // Load data
    input wire logic rvalid, // Load valid
    output logic req = 1'b0, // Request
    output logic req_we = 1'b0, // Store
    output data_memory_pkg::addr_mode_t req_mode = data_memory_pkg::AM_DIRECT, // Mode
    output logic [15:0] req_addr = 16'h0000, // Address
    output logic [1:0] req_ptr = 2'h0, // Pointer
    output logic [5:0] req_disp = 6'h00, // Displacement
    output logic [7:0] req_wdata = 8'h00 // Store data
);
    // One access; wt waits out a stall, else the request may be dropped
    task automatic acc(input logic we, input data_memory_pkg::addr_mode_t m,
        input logic [15:0] a, input logic [1:0] p, input logic [5:0] d,
        input logic [7:0] w, input logic wt, output logic [7:0] r, output logic o);
        @(posedge clk_sys);
        #1;
        while (wt && cpu_stall)
        begin
            @(posedge clk_sys);
            #1;
        end
        req = 1'b1;
        req_we = we;
        req_mode = m;
        req_addr = a;
        req_ptr = p;
        req_disp = d;
        req_wdata = w;
        @(posedge clk_sys);
        #1;
        r = rdata;
        o = rvalid;
        req = 1'b0;
        // Released address and store data show no stale value
        req_addr = ~req_addr;
        req_wdata = ~req_wdata;
    endtask : acc
endmodule : cpu_model

// File: tb/data_memory_assertions.sv
// Concurrent checks on the data memory ports.
// Assumes it is bound onto data_memory with one clock domain.
`timescale 1ns/1ps
module data_memory_assertions (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic req, // Access request
    input wire logic req_we, // Store
    input wire data_memory_pkg::addr_mode_t req_mode, // Mode
    input wire logic [15:0] req_addr, // Address
    input wire logic [7:0] req_wdata, // Store data
    input wire logic [7:0] rdata, // Load data
    input wire logic rvalid, // Load valid
    input wire logic pm_req, // Program read
    input wire logic pm_rvalid, // Program valid
    input wire logic cpu_stall // Stall
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Steps of an access
    // ****************************************
    sequence load_take;
        req && !req_we && !cpu_stall;
    endsequence
    sequence ctrl_kick(logic [3:0] v);
        req && req_we && !cpu_stall && req_mode == data_memory_pkg::AM_DIRECT
            && req_addr == 16'h003C && req_wdata[3:0] == v;
    endsequence
    a_load_answer: assert property (load_take |=> rvalid)
        else $error("load not answered next cycle");
    a_no_stray_valid: assert property (rvalid |-> $past(req && !req_we && !cpu_stall))
        else $error("load valid without a taken load");
    a_unmapped_zero: assert property (load_take ##0 req_addr >= 16'h00E0
        && req_mode == data_memory_pkg::AM_DIRECT |=> rdata == 8'h00)
        else $error("unmapped load not zero");
    a_read_stall: assert property (ctrl_kick(4'h1) ##1 cpu_stall
        |-> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall not four cycles");
    a_go_stall: assert property (ctrl_kick(4'h2) ##1 cpu_stall
        |-> cpu_stall [*2] ##1 !cpu_stall)
        else $error("write stall not two cycles");
    a_stall_cause: assert property ($rose(cpu_stall)
        |-> $past(req && req_we && req_addr == 16'h003C))
        else $error("stall without a control store");
    a_stall_drop: assert property (req && cpu_stall |=> !rvalid)
        else $error("request taken during stall");
    a_pm_answer: assert property (pm_req |=> pm_rvalid)
        else $error("program read not answered");
    a_pm_single: assert property (pm_rvalid |-> $past(pm_req))
        else $error("program valid without request");
endmodule : data_memory_assertions

bind data_memory data_memory_assertions i_data_memory_assertions (.*);

// File: tb/testbench.sv
// Self-checking bench for the data memory block.
// Assumes the checker binds itself; short programming times.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
$display("mismatch %0t got %h", $time, g); end end
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req;
    logic req_we;
    data_memory_pkg::addr_mode_t req_mode;
    logic [15:0] req_addr;
    logic [1:0] req_ptr;
    logic [5:0] req_disp;
    logic [7:0] req_wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic pm_req = 1'b0;
    logic [15:0] pm_byte_addr = 16'h0000;
    logic [7:0] pm_rdata;
    logic pm_rvalid;
    logic [9:0] program_counter = 10'h000;
    logic [15:0] instr;
    logic pm_load = 1'b0;
    logic [9:0] pm_load_addr = 10'h000;
    logic [15:0] pm_load_data = 16'h0000;
    logic cpu_stall;
    logic [7:0] nv_cell_view;
    logic [7:0] rd;
    logic v;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    data_memory #(.CYC_ATOMIC(20), .CYC_SPLIT(10)) i_data_memory (.*);
    cpu_model i_cpu_model (.*);
    // Clock and hang guard
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            close_out();
        end
    end
    // ****************************************
    // Access helpers
    // ****************************************
    task automatic am(input logic we, input data_memory_pkg::addr_mode_t m,
        input logic [1:0] p, input logic [5:0] d, input logic [7:0] w);
        i_cpu_model.acc(we, m, 16'h0000, p, d, w, 1'b1, rd, v);
    endtask : am
    task automatic wr(input logic [15:0] a, input logic [7:0] w);
        i_cpu_model.acc(1'b1, data_memory_pkg::AM_DIRECT, a, 2'h0, 6'h00, w, 1'b1, rd, v);
    endtask : wr
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        i_cpu_model.acc(1'b0, data_memory_pkg::AM_DIRECT, a, 2'h0, 6'h00, 8'h00, 1'b1, rd, v);
        `CHK(v, 1'b1)
        `CHK(rd, e)
    endtask : rc
    task automatic stl(input int e);
        int n;
        n = 0;
        while (cpu_stall === 1'b1 && n < 10)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `CHK(n, e)
        `CHK(cpu_stall, 1'b0)
    endtask : stl
    // Poll the busy bit until it clears; it must have stood for several polls
    task automatic idle();
        int k;
        k = 0;
        do
        begin
            i_cpu_model.acc(1'b0, data_memory_pkg::AM_DIRECT, 16'h003C, 2'h0, 6'h00, 8'h00,
                1'b1, rd, v);
            `CHK(v, 1'b1)
            k++;
        end
        while (rd[1] !== 1'b0 && k < 30);
        `CHK(rd[1], 1'b0)
        `CHK(k > 2, 1'b1)
    endtask : idle
    // Arm then go in mode m, expecting a stall of e cycles
    task automatic eg(input logic [1:0] m, input int e);
        wr(16'h003C, {2'b00, m, 4'h4});
        wr(16'h003C, {2'b00, m, 4'h2});
        stl(e);
    endtask : eg
    task automatic er(input logic [7:0] e);
        wr(16'h003C, 8'h01);
        stl(4);
        rc(16'h003D, e);
    endtask : er
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_map();
        wr(16'h0005, 8'h11);
        wr(16'h0060, 8'h22);
        wr(16'h00DF, 8'h33);
        wr(16'h00E0, 8'h44);
        rc(16'h0005, 8'h11);
        rc(16'h0060, 8'h22);
        rc(16'h00DF, 8'h33);
        rc(16'h00E0, 8'h00);
        rc(16'hFFFF, 8'h00);
    endtask : t_map
    task automatic t_ptr();
        wr(16'h001A, 8'h70);
        wr(16'h001B, 8'h00);
        am(1'b1, data_memory_pkg::AM_POSTINC, 2'h0, 6'h00, 8'hA5);
        rc(16'h001A, 8'h71);
        rc(16'h0070, 8'hA5);
        am(1'b0, data_memory_pkg::AM_PREDEC, 2'h0, 6'h00, 8'h00);
        `CHK(rd, 8'hA5)
        rc(16'h001A, 8'h70);
        wr(16'h001C, 8'h60);
        wr(16'h001D, 8'h00);
        am(1'b1, data_memory_pkg::AM_DISP, 2'h1, 6'h3F, 8'h3C);
        rc(16'h009F, 8'h3C);
        wr(16'h001E, 8'h80);
        wr(16'h001F, 8'h00);
        am(1'b1, data_memory_pkg::AM_INDIRECT, 2'h2, 6'h00, 8'hC3);
        rc(16'h0080, 8'hC3);
    endtask : t_ptr
    task automatic t_ee();
        wr(16'h003E, 8'hFF);
        rc(16'h003E, 8'h7F);
        wr(16'h003D, 8'h5A);
        eg(2'h0, 2);
        rc(16'h003C, 8'h02);
        wr(16'h003C, 8'h01);
        stl(0);
        wr(16'h003E, 8'h10);
        rc(16'h003E, 8'h7F);
        idle();
        wr(16'h003C, 8'h01);
        i_cpu_model.acc(1'b0, data_memory_pkg::AM_DIRECT, 16'h0060, 2'h0, 6'h00, 8'h00,
            1'b0, rd, v);
        `CHK(v, 1'b0)
        stl(2);
        rc(16'h003D, 8'h5A);
        `CHK(nv_cell_view, 8'h5A)
        eg(2'h1, 2);
        idle();
        er(8'hFF);
        wr(16'h003D, 8'h0F);
        eg(2'h2, 2);
        idle();
        er(8'h0F);
        eg(2'h3, 0);
        repeat (4) @(posedge clk_sys);
        rc(16'h003C, 8'h30);
        wr(16'h003C, 8'h00);
    endtask : t_ee
    task automatic t_guard();
        wr(16'h003C, 8'h02);
        stl(0);
        wr(16'h003C, 8'h06);
        stl(0);
        wr(16'h003C, 8'h04);
        repeat (5) @(posedge clk_sys);
        wr(16'h003C, 8'h02);
        stl(0);
        rc(16'h003C, 8'h00);
        er(8'h0F);
    endtask : t_guard
    task automatic t_pm();
        pm_load = 1'b1;
        pm_load_addr = 10'h3FF;
        pm_load_data = 16'hABCD;
        @(posedge clk_sys);
        #1;
        pm_load = 1'b0;
        pm_req = 1'b1;
        pm_byte_addr = 16'h07FF;
        program_counter = 10'h3FF;
        @(posedge clk_sys);
        #1;
        pm_req = 1'b0;
        `CHK(pm_rvalid, 1'b1)
        `CHK(pm_rdata, 8'hAB)
        `CHK(instr, 16'hABCD)
    endtask : t_pm
    // Mid-run reset after an arm store clears the control bits; stall and load valid stay low
    task automatic t_rst();
        wr(16'h003C, 8'h14);
        rst_n = 1'b0;
        @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        `CHK(cpu_stall, 1'b0)
        `CHK(rvalid, 1'b0)
        rc(16'h003C, 8'h00);
    endtask : t_rst
    task automatic close_out();
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    // Reset, then the scenarios in turn
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_map();
        t_ptr();
        t_ee();
        t_guard();
        t_pm();
        t_rst();
        close_out();
    end
endmodule : testbench
